// ---- lsts_map.vh ----
// register offsets, field positions, limits and error codes of the list setup block
`ifndef LSTS_MAP_VH
`define LSTS_MAP_VH
// ************************************************************
// register byte addresses
// ************************************************************
`define LSTS_CTRL        8'h00
`define LSTS_LEVEL       8'h04
`define LSTS_DWELL       8'h08
`define LSTS_SAMP_CURR   8'h0c
`define LSTS_SAMP_VOLT   8'h10
`define LSTS_SAMP_WIDTH  8'h14
`define LSTS_TRIG_WIDTH  8'h18
`define LSTS_WAIT        8'h1c
`define LSTS_TRIG_POINT  8'h20
`define LSTS_RES_LO      8'h24
`define LSTS_RES_HI      8'h28
`define LSTS_POINTS      8'h2c
`define LSTS_ERRQ        8'h30
`define LSTS_SAMP_SEL    8'h34
`define LSTS_SAMP_LOC    8'h38
// ************************************************************
// field positions
// ************************************************************
`define LSTS_CTRL_CLEAR  0
`define LSTS_CTRL_RES    1
`define LSTS_LEVEL_CURR  31
`define LSTS_TRIG_POL    16
`define LSTS_AVG_LSB     16
`define LSTS_AVG_MSB     24
// ************************************************************
// limits, times in microseconds
// ************************************************************
`define LSTS_RES_MIN     13'h0f5d
`define LSTS_RES_MAX     13'h170c
`define LSTS_DWELL_MIN   16'h005d
`define LSTS_DWELL_MAX   16'h84d0
`define LSTS_PULSE_MIN   16'h00fa
`define LSTS_PULSE_MAX   16'h84d0
`define LSTS_SAMP_LIMIT  4'h8
`define LSTS_CLOCK_MHZ   100
// ************************************************************
// error codes, two's complement
// ************************************************************
`define LSTS_ERR_CMD     32'hffffff9c
`define LSTS_ERR_CONF    32'hffffff23
`define LSTS_ERR_RANGE   32'hffffff22
`define LSTS_ERR_MUCH    32'hffffff21
`define LSTS_ERR_LEN     32'hffffff1e
`define LSTS_ERRQ_DEPTH  4'h8
`endif

// ---- lsts_list_setup.v ----
// list sample and trigger setup: command checks, pointers, error queue, flag pulse
`timescale 1ns/100ps
`include "lsts_map.vh"

// How it works
// R1: resolution 3933 or 5900 caps level, dwell and trigger points; samples stay capped at 3933
// R2: report dwell bounds, reject dwell outside
// R3: averaging count is power of two
// R4: other averaging counts round down, 0 and 1 lift to 2
// R5: sample appends average-count points
// R6: sample without prior setup gives -221
// R7: host sets sample width before samples
// R8: unequal dwell and level lengths -226
// R9: ninth sample command gives -223
// R10: points beyond 3933 give -223
// R11: sample location readback with list type
// R12: sample width range, second set -100
// R13: reading unset sample width errors
// R14: trigger width makes flag follow pulses
// R15: polarity chooses flag state during pulse
// R16: reading unset trigger width errors
// R17: wait timeout range, reads 0 unset
// R18: trigger point drives flag for width
// R19: trigger point before width gives -221
// R20: trigger point without level gives -221
// R21: clear returns all pointers to zero; sampSel and the error queue pointers keep theirs
// R22: refused commands queue error, list unchanged
module lsts_list_setup #(
	parameter CYCLES_PER_US = `LSTS_CLOCK_MHZ
) (
	input  wire        clock,
	input  wire        rst,
	input  wire [7:0]  address,
	input  wire [31:0] writeData,
	input  wire        writeStrobe,
	input  wire        readStrobe,
	output reg  [31:0] readData,
	output reg         stepValid,
	output reg  [15:0] stepLevel,
	output reg  [8:0]  stepCount,
	output reg         stepSample,
	output reg         stepTrigger,
	input  wire        stepFire,
	input  wire        stepFireTrig,
	input  wire        outputOffFlag,
	output wire        flagConduct
);
	// ************************************************************
	// state
	// ************************************************************
	reg        resMax;
	reg [12:0] levelCount;
	reg [12:0] dwellCount;
	reg        levelSeen;
	reg        listCurrent;
	reg [3:0]  sampleCount;
	reg        sampWidthSet;
	reg [15:0] sampWidth;
	reg        trigWidthSet;
	reg        trigPol;
	reg [15:0] trigWidth;
	reg [15:0] waitTime;
	reg [12:0] sampLoc [0:7];
	reg [2:0]  sampSel;
	reg [21:0] pulseCnt;
	reg [31:0] errMem [0:7];
	reg [2:0]  errHead;
	reg [2:0]  errTail;
	reg [3:0]  errFill;

	wire        wr = writeStrobe;
	wire [15:0] arg = writeData[15:0];
	wire [8:0]  rawAvg = writeData[`LSTS_AVG_MSB:`LSTS_AVG_LSB];
	wire [12:0] pointCap = resMax ? `LSTS_RES_MAX : `LSTS_RES_MIN; // [R1]
	wire        argPulseOk = (arg >= `LSTS_PULSE_MIN) && (arg <= `LSTS_PULSE_MAX);
	wire        isSample = wr && ((address == `LSTS_SAMP_CURR) ||
		(address == `LSTS_SAMP_VOLT));
	wire        isTrigPt = wr && (address == `LSTS_TRIG_POINT);

	// ************************************************************
	// averaging count: largest permitted power of two not above raw
	// ************************************************************
	reg [8:0] avg;
	always @* begin
		if (rawAvg[8])
			avg = 9'h100;
		else if (rawAvg[7])
			avg = 9'h080;
		else if (rawAvg[6])
			avg = 9'h040;
		else if (rawAvg[5])
			avg = 9'h020;
		else if (rawAvg[4])
			avg = 9'h010;
		else if (rawAvg[3])
			avg = 9'h008;
		else if (rawAvg[2])
			avg = 9'h004;
		else
			avg = 9'h002; // nothing lower is permitted, so 0 and 1 lift to 2
	end // [R3] [R4]

	// ************************************************************
	// command checks; one error at most per cycle
	// ************************************************************
	reg        next_errPush;
	reg [31:0] next_errCode;
	wire [13:0] sampEnd = {1'b0, levelCount} + {5'h00, avg};
	wire [13:0] trigEnd = {1'b0, levelCount} + 14'h0001;
	always @* begin
		next_errPush = 1'b0;
		next_errCode = 32'h00000000;
		if (isSample) begin
			if (!sampWidthSet || !levelSeen) begin
				next_errPush = 1'b1;
				next_errCode = `LSTS_ERR_CONF; // [R6] [R7]
			end else if (levelCount != dwellCount) begin
				next_errPush = 1'b1;
				next_errCode = `LSTS_ERR_LEN; // [R8]
			end else if (sampleCount == `LSTS_SAMP_LIMIT) begin
				next_errPush = 1'b1;
				next_errCode = `LSTS_ERR_MUCH; // [R9]
			end else if (sampEnd > {1'b0, `LSTS_RES_MIN}) begin
				next_errPush = 1'b1;
				next_errCode = `LSTS_ERR_MUCH; // [R10]
			end
		end else if (isTrigPt) begin
			if (!trigWidthSet || !levelSeen) begin
				next_errPush = 1'b1;
				next_errCode = `LSTS_ERR_CONF; // [R19] [R20]
			end else if (levelCount != dwellCount) begin
				next_errPush = 1'b1;
				next_errCode = `LSTS_ERR_LEN; // [R8]
			end else if (trigEnd > {1'b0, pointCap}) begin
				next_errPush = 1'b1;
				next_errCode = `LSTS_ERR_MUCH;
			end
		end else if (wr) begin
			case (address)
			`LSTS_LEVEL: begin
				if (levelSeen && (listCurrent != writeData[`LSTS_LEVEL_CURR])) begin
					next_errPush = 1'b1;
					next_errCode = `LSTS_ERR_CONF;
				end else if (levelCount == pointCap) begin
					next_errPush = 1'b1;
					next_errCode = `LSTS_ERR_MUCH; // [R1]
				end
			end
			`LSTS_DWELL: begin
				if ((arg < `LSTS_DWELL_MIN) || (arg > `LSTS_DWELL_MAX)) begin
					next_errPush = 1'b1;
					next_errCode = `LSTS_ERR_RANGE; // [R2]
				end else if (dwellCount == pointCap) begin
					next_errPush = 1'b1;
					next_errCode = `LSTS_ERR_MUCH;
				end
			end
			`LSTS_SAMP_WIDTH: begin
				if (sampWidthSet) begin
					next_errPush = 1'b1;
					next_errCode = `LSTS_ERR_CMD; // [R12]
				end else if (!argPulseOk) begin
					next_errPush = 1'b1;
					next_errCode = `LSTS_ERR_RANGE; // [R12]
				end
			end
			`LSTS_TRIG_WIDTH, `LSTS_WAIT: begin
				if (!argPulseOk) begin
					next_errPush = 1'b1;
					next_errCode = `LSTS_ERR_RANGE; // [R14] [R17]
				end
			end
			default: begin
				next_errPush = 1'b0;
			end
			endcase
		end else if (readStrobe && (address == `LSTS_SAMP_WIDTH) && !sampWidthSet) begin
			next_errPush = 1'b1;
			next_errCode = `LSTS_ERR_CMD; // [R13]
		end else if (readStrobe && (address == `LSTS_TRIG_WIDTH) && !trigWidthSet) begin
			next_errPush = 1'b1;
			next_errCode = `LSTS_ERR_CMD; // [R16]
		end
	end

	wire accept = wr && !next_errPush;
	wire clearCmd = accept && (address == `LSTS_CTRL) && writeData[`LSTS_CTRL_CLEAR];

	// ************************************************************
	// list pointers and settings; refused writes change nothing
	// ************************************************************
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			resMax <= 1'b0;
			levelCount <= 13'h0000;
			dwellCount <= 13'h0000;
			levelSeen <= 1'b0;
			listCurrent <= 1'b0;
			sampleCount <= 4'h0;
			sampWidthSet <= 1'b0;
			sampWidth <= 16'h0000;
			trigWidthSet <= 1'b0;
			trigPol <= 1'b0;
			trigWidth <= 16'h0000;
			waitTime <= 16'h0000;
			sampSel <= 3'h0;
		end else if (clearCmd) begin
			// [R21] level, dwell and sample counts back to zero, setup flags forgotten; sampSel and error queue kept
			resMax <= writeData[`LSTS_CTRL_RES];
			levelCount <= 13'h0000;
			dwellCount <= 13'h0000;
			levelSeen <= 1'b0;
			sampleCount <= 4'h0;
			sampWidthSet <= 1'b0;
			trigWidthSet <= 1'b0; // [R14] flag back to output state
			waitTime <= 16'h0000;
		end else if (accept) begin
			case (address)
			`LSTS_CTRL: begin
				resMax <= writeData[`LSTS_CTRL_RES];
			end
			`LSTS_LEVEL: begin
				levelCount <= levelCount + 13'h0001;
				levelSeen <= 1'b1;
				listCurrent <= writeData[`LSTS_LEVEL_CURR];
			end
			`LSTS_DWELL: begin
				dwellCount <= dwellCount + 13'h0001;
			end
			`LSTS_SAMP_CURR, `LSTS_SAMP_VOLT: begin
				// sample points carry their own hold, so both lists grow alike
				levelCount <= sampEnd[12:0]; // [R5]
				dwellCount <= sampEnd[12:0];
				sampleCount <= sampleCount + 4'h1;
			end
			`LSTS_TRIG_POINT: begin
				levelCount <= trigEnd[12:0];
				dwellCount <= trigEnd[12:0];
			end
			`LSTS_SAMP_WIDTH: begin
				sampWidth <= arg;
				sampWidthSet <= 1'b1; // [R12]
			end
			`LSTS_TRIG_WIDTH: begin
				trigWidth <= arg;
				trigPol <= writeData[`LSTS_TRIG_POL];
				trigWidthSet <= 1'b1; // [R14]
			end
			`LSTS_WAIT: begin
				waitTime <= arg; // [R17]
			end
			`LSTS_SAMP_SEL: begin
				sampSel <= writeData[2:0];
			end
			default: begin
				sampSel <= sampSel;
			end
			endcase
		end
	end

	// ************************************************************
	// sample locations, point after which each sample is taken
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : gLoc
			always @(posedge clock or posedge rst) begin
				if (rst)
					sampLoc[gi] <= 13'h0000;
				else if (accept && isSample && (sampleCount == gi))
					sampLoc[gi] <= sampEnd[12:0] - 13'h0001; // [R11]
			end
		end
	endgenerate

	// ************************************************************
	// step output toward the sequencer table
	// ************************************************************
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			stepValid <= 1'b0;
			stepLevel <= 16'h0000;
			stepCount <= 9'h000;
			stepSample <= 1'b0;
			stepTrigger <= 1'b0;
		end else begin
			stepValid <= accept && (isSample || isTrigPt); // [R22]
			stepLevel <= arg;
			stepCount <= isSample ? avg : 9'h001; // [R5]
			stepSample <= isSample;
			stepTrigger <= isTrigPt; // [R18]
		end
	end

	// ************************************************************
	// trigger pulse on the output-off flag
	// ************************************************************
	// 22 bits hold the longest width; the product stays inside 32 bits
	wire [31:0] pulseLoad = trigWidth * CYCLES_PER_US;
	always @(posedge clock or posedge rst) begin
		if (rst)
			pulseCnt <= 22'h000000;
		else if (clearCmd)
			pulseCnt <= 22'h000000;
		else if (stepFire && stepFireTrig && trigWidthSet)
			pulseCnt <= pulseLoad[21:0]; // [R18]
		else if (pulseCnt != 22'h000000)
			pulseCnt <= pulseCnt - 22'h000001;
	end
	wire pulseOn = (pulseCnt != 22'h000000);
	// [R14] [R15] polarity picks the conducting state while the pulse runs
	assign flagConduct = trigWidthSet ? (pulseOn ? trigPol : ~trigPol) : outputOffFlag;

	// ************************************************************
	// error queue; a full queue drops the newest code
	// ************************************************************
	wire errPop = readStrobe && (address == `LSTS_ERRQ) && (errFill != 4'h0);
	wire errPush = next_errPush && (errFill != `LSTS_ERRQ_DEPTH);
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			errHead <= 3'h0;
			errTail <= 3'h0;
			errFill <= 4'h0;
		end else begin
			if (errPush)
				errTail <= errTail + 3'h1; // [R22]
			if (errPop)
				errHead <= errHead + 3'h1;
			if (errPush && !errPop)
				errFill <= errFill + 4'h1;
			else if (errPop && !errPush)
				errFill <= errFill - 4'h1;
		end
	end
	always @(posedge clock) begin
		if (errPush)
			errMem[errTail] <= next_errCode;
	end

	// ************************************************************
	// read port, data one cycle after the strobe
	// ************************************************************
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			readData <= 32'h00000000;
		end else if (readStrobe) begin
			case (address)
			`LSTS_CTRL: readData <= {30'h00000000, resMax, 1'b0};
			`LSTS_SAMP_WIDTH: readData <= sampWidthSet ? {16'h0000, sampWidth} : 32'h00000000;
			`LSTS_TRIG_WIDTH: readData <= trigWidthSet ?
				{15'h0000, trigPol, trigWidth} : 32'h00000000;
			`LSTS_WAIT: readData <= {16'h0000, waitTime}; // [R17]
			`LSTS_RES_LO: readData <= {16'h0000, `LSTS_DWELL_MIN}; // [R2]
			`LSTS_RES_HI: readData <= {16'h0000, `LSTS_DWELL_MAX};
			`LSTS_POINTS: readData <= {3'h0, levelCount, 3'h0, pointCap}; // [R1]
			`LSTS_ERRQ: readData <= (errFill != 4'h0) ? errMem[errHead] : 32'h00000000;
			`LSTS_SAMP_SEL: readData <= {28'h0000000, sampleCount};
			`LSTS_SAMP_LOC: readData <= {listCurrent, 14'h0000, (sampSel < sampleCount),
				3'h0, sampLoc[sampSel]}; // [R11]
			default: readData <= 32'h00000000;
			endcase
		end else begin
			readData <= 32'h00000000;
		end
	end
endmodule

// ---- lsts_list_properties.sv ----
// concurrent checks on the list setup block ports
`timescale 1ns/100ps
`include "lsts_map.vh"
// ************************************************************
// port checker
// ************************************************************
module lsts_list_properties #(
	parameter CYCLES_PER_US = 100
) (
	input wire        clock,
	input wire        rst,
	input wire [7:0]  address,
	input wire [31:0] writeData,
	input wire        writeStrobe,
	input wire        readStrobe,
	input wire [31:0] readData,
	input wire        stepValid,
	input wire [15:0] stepLevel,
	input wire [8:0]  stepCount,
	input wire        stepSample,
	input wire        stepTrigger,
	input wire        stepFire,
	input wire        stepFireTrig,
	input wire        outputOffFlag,
	input wire        flagConduct
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// writes that may append points
	wire pointWr = writeStrobe && (address == `LSTS_SAMP_CURR || address == `LSTS_SAMP_VOLT
		|| address == `LSTS_TRIG_POINT);
	sequence s_step_out;
		stepValid ##0 (stepSample ^ stepTrigger);
	endsequence
	sequence s_pulse_start;
		(stepFire && stepFireTrig) ##1 ($changed(flagConduct) && $stable(outputOffFlag));
	endsequence
	a_read_idle: assert property (!readStrobe |=> readData == 32'h0)
		else $error("read data not idle");
	a_step_cause: assert property (stepValid |-> s_step_out and $past(pointWr))
		else $error("step without accepted point write");
	a_trig_single: assert property (stepValid && stepTrigger |->
		stepCount == 9'h1 && $past(address) == `LSTS_TRIG_POINT) else $error("bad trigger step");
	a_samp_pow: assert property (stepValid && stepSample |->
		$onehot(stepCount) && stepCount > 9'h1) else $error("average not a power of two");
	a_samp_round: assert property (stepValid && stepSample |->
		($past(writeData[24:16]) < 9'h2) ? (stepCount == 9'h2) :
		(stepCount <= $past(writeData[24:16]) && (stepCount[8] ||
		{stepCount, 1'b0} > {1'b0, $past(writeData[24:16])}))) else $error("average not rounded down");
	a_step_level: assert property (stepValid |-> stepLevel == $past(writeData[15:0]))
		else $error("step level differs from write");
	a_clear_quiet: assert property (writeStrobe && address == `LSTS_CTRL |=> !stepValid)
		else $error("step after clear");
	a_pulse_hold: assert property (s_pulse_start |=> $stable(flagConduct) [*8])
		else $error("flag pulse too short");
endmodule
bind lsts_list_setup lsts_list_properties #(.CYCLES_PER_US(CYCLES_PER_US)) lsts_list_properties_i (
	.clock(clock), .rst(rst), .address(address), .writeData(writeData),
	.writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
	.stepValid(stepValid), .stepLevel(stepLevel), .stepCount(stepCount),
	.stepSample(stepSample), .stepTrigger(stepTrigger), .stepFire(stepFire),
	.stepFireTrig(stepFireTrig), .outputOffFlag(outputOffFlag), .flagConduct(flagConduct));

// ---- lsts_seq_model.sv ----
// sequencer stand-in that plays steps into the list setup block
`timescale 1ns/100ps
// ************************************************************
// step player
// ************************************************************
module lsts_seq_model (
	input  wire clock,
	input  wire rst,
	input  wire playReq,
	input  wire playTrig,
	output reg  stepFire,
	output reg  stepFireTrig
);
	// one pulse per request; the trigger mark never outlives the pulse
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			stepFire     <= 1'b0;
			stepFireTrig <= 1'b0;
		end else begin
			stepFire     <= playReq;
			stepFireTrig <= playReq & playTrig;
		end
	end
endmodule

// ---- tb_top.sv ----
// self-checking bench for the list setup block
`timescale 1ns/100ps
`include "lsts_map.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("BAD t=%0t got %h exp %h", $time, g, e); end end
// ************************************************************
// bench top
// ************************************************************
module tb_top;
	reg         clock = 1'b0;
	reg         rst = 1'b1;
	reg  [7:0]  address = 8'h00;
	reg  [31:0] writeData = 32'h0;
	reg         writeStrobe = 1'b0;
	reg         readStrobe = 1'b0;
	reg         outputOffFlag = 1'b0;
	reg         playReq = 1'b0;
	reg         playTrig = 1'b0;
	wire [31:0] readData;
	wire [15:0] stepLevel;
	wire [8:0]  stepCount;
	wire        stepValid, stepSample, stepTrigger, stepFire, stepFireTrig, flagConduct;
	integer     failures = 0;
	integer     n_checks = 0;
	integer     seed = 32'hd177e94b;
	integer     i, n, pt;
	reg         rdPend = 1'b0;
	reg  [8:0]  av;
	reg  [15:0] lv;
	reg  [31:0] rq[$];
	reg  [26:0] sq[$];
	reg  [31:0] expR;
	reg  [26:0] expS;
	lsts_list_setup #(.CYCLES_PER_US(1)) lsts_list_setup_i (
		.clock(clock), .rst(rst), .address(address), .writeData(writeData),
		.writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
		.stepValid(stepValid), .stepLevel(stepLevel), .stepCount(stepCount),
		.stepSample(stepSample), .stepTrigger(stepTrigger), .stepFire(stepFire),
		.stepFireTrig(stepFireTrig), .outputOffFlag(outputOffFlag), .flagConduct(flagConduct));
	lsts_seq_model lsts_seq_model_i (.clock(clock), .rst(rst), .playReq(playReq),
		.playTrig(playTrig), .stepFire(stepFire), .stepFireTrig(stepFireTrig));
	always #5 clock = ~clock;
	// results are settled by the falling edge, so compare there
	always @(posedge clock) rdPend <= readStrobe;
	// notes are popped once, so a mismatch print cannot eat the next note
	always @(negedge clock) begin
		if (rdPend) begin
			expR = rq.pop_front();
			`CHK(readData, expR)
		end
		if (stepValid !== 1'b0) begin
			if (sq.size() == 0) begin
				`CHK(stepValid, 1'b0)
			end else begin
				expS = sq.pop_front();
				`CHK({stepTrigger, stepSample, stepCount, stepLevel}, expS)
			end
		end
	end
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge clock);
			address <= a;
			writeData <= d;
			writeStrobe <= 1'b1;
			@(posedge clock);
			writeStrobe <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [31:0] e);
		begin
			rq.push_back(e);
			@(posedge clock);
			address <= a;
			readStrobe <= 1'b1;
			@(posedge clock);
			readStrobe <= 1'b0;
		end
	endtask
	// counts pulse cycles where the flag leaves its idle level
	task play(input t, input idle, output integer cnt);
		begin
			cnt = 0;
			@(posedge clock);
			playReq <= 1'b1;
			playTrig <= t;
			@(posedge clock);
			playReq <= 1'b0;
			repeat (300) @(negedge clock) if (flagConduct !== idle) cnt++;
		end
	endtask
	function [8:0] rnd(input [8:0] v);
		integer p;
		begin
			rnd = 9'h2;
			for (p = 4; p <= 256; p = p * 2) if (v >= p) rnd = p[8:0];
		end
	endfunction
	task stop_test;
		begin
			$display("checks %0d failures %0d", n_checks, failures);
			if (failures == 0 && n_checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	// hang guard, well past the expected run length
	initial begin
		#600000;
		failures++;
		stop_test;
	end
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		rd(`LSTS_RES_LO, 32'd93);
		rd(`LSTS_RES_HI, 32'd34000);
		rd(`LSTS_POINTS, 32'h00000f5d);
		wr(`LSTS_CTRL, 32'h2);
		rd(`LSTS_CTRL, 32'h2);
		rd(`LSTS_POINTS, 32'h0000170c);
		wr(`LSTS_CTRL, 32'h1);
		rd(`LSTS_WAIT, 32'h0);
		wr(`LSTS_WAIT, 32'd249);
		rd(`LSTS_ERRQ, `LSTS_ERR_RANGE);
		wr(`LSTS_WAIT, 32'd300);
		rd(`LSTS_WAIT, 32'd300);
		rd(`LSTS_SAMP_WIDTH, 32'h0);
		rd(`LSTS_ERRQ, `LSTS_ERR_CMD);
		rd(`LSTS_TRIG_WIDTH, 32'h0);
		rd(`LSTS_ERRQ, `LSTS_ERR_CMD);
		$display("test bounds done");
		wr(`LSTS_SAMP_CURR, 32'h00020005);
		rd(`LSTS_ERRQ, `LSTS_ERR_CONF);
		wr(`LSTS_TRIG_POINT, 32'h5);
		rd(`LSTS_ERRQ, `LSTS_ERR_CONF);
		wr(`LSTS_SAMP_WIDTH, 32'd249);
		rd(`LSTS_ERRQ, `LSTS_ERR_RANGE);
		wr(`LSTS_SAMP_WIDTH, 32'd250);
		wr(`LSTS_SAMP_WIDTH, 32'd300);
		rd(`LSTS_ERRQ, `LSTS_ERR_CMD);
		rd(`LSTS_SAMP_WIDTH, 32'd250);
		wr(`LSTS_TRIG_WIDTH, 32'd250);
		wr(`LSTS_TRIG_POINT, 32'h5);
		rd(`LSTS_ERRQ, `LSTS_ERR_CONF);
		rd(`LSTS_ERRQ, 32'h0);
		$display("test refusals done");
		wr(`LSTS_LEVEL, 32'h80000007);
		wr(`LSTS_DWELL, 32'd92);
		wr(`LSTS_DWELL, 32'd34001);
		rd(`LSTS_ERRQ, `LSTS_ERR_RANGE);
		rd(`LSTS_ERRQ, `LSTS_ERR_RANGE);
		wr(`LSTS_DWELL, 32'd34000);
		pt = 1;
		// random averages cover exact powers and the round-down band alike
		for (i = 0; i < 8; i++) begin
			av = $random(seed);
			lv = $random(seed);
			sq.push_back({2'b01, rnd(av), lv});
			pt = pt + rnd(av);
			wr(`LSTS_SAMP_CURR, {7'h0, av, lv});
		end
		wr(`LSTS_SAMP_CURR, 32'h00020001);
		rd(`LSTS_ERRQ, `LSTS_ERR_MUCH);
		rd(`LSTS_SAMP_SEL, 32'h8);
		wr(`LSTS_SAMP_SEL, 32'h7);
		rd(`LSTS_SAMP_LOC, 32'h80010000 + pt - 1);
		wr(`LSTS_LEVEL, 32'h00000001);
		rd(`LSTS_ERRQ, `LSTS_ERR_CONF);
		sq.push_back({2'b10, 9'h1, 16'h1234});
		wr(`LSTS_TRIG_POINT, 32'h1234);
		wr(`LSTS_LEVEL, 32'h80000001);
		wr(`LSTS_SAMP_CURR, 32'h00040001);
		rd(`LSTS_ERRQ, `LSTS_ERR_LEN);
		wr(`LSTS_TRIG_POINT, 32'h1);
		rd(`LSTS_ERRQ, `LSTS_ERR_LEN);
		$display("test samples done");
		wr(`LSTS_CTRL, 32'h1);
		wr(`LSTS_SAMP_WIDTH, 32'd250);
		for (i = 0; i < 3805; i++) begin
			wr(`LSTS_LEVEL, i);
			wr(`LSTS_DWELL, 32'd93);
		end
		wr(`LSTS_SAMP_VOLT, 32'h01000002);
		rd(`LSTS_ERRQ, `LSTS_ERR_MUCH);
		sq.push_back({2'b01, 9'h80, 16'h0002});
		wr(`LSTS_SAMP_VOLT, 32'h00800002);
		rd(`LSTS_POINTS, 32'h0f5d0f5d);
		wr(`LSTS_LEVEL, 32'h5);
		wr(`LSTS_DWELL, 32'd93);
		rd(`LSTS_ERRQ, `LSTS_ERR_MUCH);
		rd(`LSTS_ERRQ, `LSTS_ERR_MUCH);
		$display("test capacity done");
		wr(`LSTS_CTRL, 32'h1);
		rd(`LSTS_POINTS, 32'h00000f5d);
		rd(`LSTS_SAMP_SEL, 32'h0);
		rd(`LSTS_WAIT, 32'h0);
		outputOffFlag <= 1'b1;
		@(negedge clock) `CHK(flagConduct, 1'b1)
		wr(`LSTS_TRIG_WIDTH, 32'h000100fa);
		wr(`LSTS_LEVEL, 32'h3);
		wr(`LSTS_DWELL, 32'd93);
		sq.push_back({2'b10, 9'h1, 16'h0009});
		wr(`LSTS_TRIG_POINT, 32'h9);
		play(1'b0, 1'b0, n);
		`CHK(n, 0)
		play(1'b1, 1'b0, n);
		`CHK(n, 250)
		wr(`LSTS_TRIG_WIDTH, 32'h000000fa);
		play(1'b1, 1'b1, n);
		`CHK(n, 250)
		wr(`LSTS_CTRL, 32'h1);
		outputOffFlag <= 1'b0;
		@(negedge clock) `CHK(flagConduct, 1'b0)
		repeat (3) @(posedge clock);
		`CHK(sq.size(), 0)
		$display("test flag done");
		stop_test;
	end
endmodule
